// File: verilog/idio_consts.svh
// Purpose: Offsets, field positions and reset values of the isolated digital I/O block
// Assumes: Word-indexed plain register port, 16-bit data
// Notes:   Definitions only
`ifndef IDIO_CONSTS_SVH
`define IDIO_CONSTS_SVH

`define IDIO_ADDR_W         4
`define IDIO_DATA_W         16
`define IDIO_NUM_CH         16
`define IDIO_NUM_SRC        8

// Register offsets
`define IDIO_OFF_INPUTS     4'h0
`define IDIO_OFF_PORT1      4'h1
`define IDIO_OFF_PORT2      4'h2
`define IDIO_OFF_CHAN_SEL   4'h3
`define IDIO_OFF_CHAN_LVL   4'h4
`define IDIO_OFF_OUTPUTS    4'h5
`define IDIO_OFF_IRQ_SRC    4'h6

// Interrupt source bit positions
`define IDIO_SRC_EVENT1     0
`define IDIO_SRC_EVENT2     1
`define IDIO_SRC_CNT1       2
`define IDIO_SRC_CNT2       3
`define IDIO_SRC_CNT3       4
`define IDIO_SRC_WDOG       5
`define IDIO_SRC_VOLT       6
`define IDIO_SRC_SHORT      7

// Reset values
`define IDIO_RST_OUTPUTS    16'h0000
`define IDIO_RST_SRC        8'h00
`define IDIO_RST_CHAN_SEL   4'h0
`define IDIO_RST_RDATA      16'h0000

`endif

// File: verilog/idio_pkg.sv
// Purpose: Types shared by the isolated digital I/O block
// Assumes: Constants live in idio_consts.svh
// Notes:   Types only
package idio_pkg;
    typedef logic [15:0] idio_word_type;
    typedef logic [7:0]  idio_byte_type;
endpackage

// File: verilog/idio_sync3.sv
// Purpose: Three-stage synchroniser with agreement filter for one pin
// Assumes: Single clock clk, synchronous active-high reset
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module idio_sync3 (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    output var  logic level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    wire  agree = (s2_q == s3_q);

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree) begin
                lvl_q <= s3_q;
            end
        end
    end

    assign level = lvl_q;
endmodule
`default_nettype wire

// File: verilog/idio_top.sv
// Purpose: Isolated 16-in/16-out digital port with interrupt source byte
// Assumes: 10 MHz clk, synchronous active-high rst, plain register port
// Notes:   Source byte clears on read; set wins over the read clear
//
// Overview of operation
// - Source byte bits are event1, event2, counters 1..3, watchdog, voltage and short.
// - Several source bits may be set together and are all seen in one read.
// - Host learns whether an interrupt was raised and which cause from the source byte.
// - All sixteen inputs read as one 16-bit word captured in one access.
// - Input 1 sits at bit 0 and input 16 at bit 15; one means voltage present.
// - Either input port 1 or 2 reads alone as a byte, input 1 lowest in port 1.
// - Any single input 1 to 16 reads as 0 for low and 1 for high.
// - One 16-bit write sets all outputs, one drives on, output 1 at bit 0.
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "idio_consts.svh"
module idio_top
    import idio_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic [`IDIO_ADDR_W-1:0]  addr,
    input  wire logic [`IDIO_DATA_W-1:0]  wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    output var  logic [`IDIO_DATA_W-1:0]  rdata,
    input  wire logic [`IDIO_NUM_CH-1:0]  din_pins,
    output var  logic [`IDIO_NUM_CH-1:0]  dout_pins,
    input  wire logic [`IDIO_NUM_SRC-1:0] src_pulse,
    output var  logic                     irq
);
    // ************************************
    // Input synchronisers
    // ************************************
    idio_word_type din_sync;

    genvar gi;
    generate
        for (gi = 0; gi < `IDIO_NUM_CH; gi++) begin : g_sync
            idio_sync3 u_sync (
                .clk   (clk),
                .rst   (rst),
                .pin   (din_pins[gi]),
                .level (din_sync[gi])
            );
        end
    endgenerate

    // ************************************
    // Registers
    // ************************************
    idio_word_type  out_q;
    idio_byte_type  src_q;
    logic [3:0]     chan_sel_q;
    idio_word_type  rdata_q;
    logic           irq_q;

    wire wr_out  = wr && (addr == `IDIO_OFF_OUTPUTS);
    wire wr_sel  = wr && (addr == `IDIO_OFF_CHAN_SEL);
    wire rd_src  = rd && (addr == `IDIO_OFF_IRQ_SRC);
    wire rd_word = rd && (addr == `IDIO_OFF_INPUTS);
    wire rd_prt1 = rd && (addr == `IDIO_OFF_PORT1);
    wire rd_prt2 = rd && (addr == `IDIO_OFF_PORT2);
    wire rd_sel  = rd && (addr == `IDIO_OFF_CHAN_SEL);
    wire rd_lvl  = rd && (addr == `IDIO_OFF_CHAN_LVL);
    wire rd_out  = rd && (addr == `IDIO_OFF_OUTPUTS);

    // Set wins over the read clear
    idio_byte_type src_d;
    assign src_d = (rd_src ? `IDIO_RST_SRC : src_q) | src_pulse;

    wire single_lvl = din_sync[chan_sel_q];

    idio_word_type rd_mux;
    assign rd_mux =
        (addr == `IDIO_OFF_INPUTS)   ? din_sync :
        (addr == `IDIO_OFF_PORT1)    ? {8'h00, din_sync[7:0]} :
        (addr == `IDIO_OFF_PORT2)    ? {8'h00, din_sync[15:8]} :
        (addr == `IDIO_OFF_CHAN_SEL) ? {12'h000, chan_sel_q} :
        (addr == `IDIO_OFF_CHAN_LVL) ? {15'h0000, single_lvl} :
        (addr == `IDIO_OFF_OUTPUTS)  ? out_q :
        (addr == `IDIO_OFF_IRQ_SRC)  ? {8'h00, src_q} :
        16'h0000;

    // ************************************
    // Output register
    // ************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            out_q <= `IDIO_RST_OUTPUTS;
        end else if (wr_out) begin
            out_q <= wdata;
        end
    end

    // ************************************
    // Channel select register
    // ************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            chan_sel_q <= `IDIO_RST_CHAN_SEL;
        end else if (wr_sel) begin
            chan_sel_q <= wdata[3:0];
        end
    end

    // ************************************
    // Source byte and request
    // ************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            src_q <= `IDIO_RST_SRC;
            irq_q <= 1'b0;
        end else begin
            src_q <= src_d;
            irq_q <= |src_d;
        end
    end

    // ************************************
    // Read data register
    // ************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= `IDIO_RST_RDATA;
        end else begin
            rdata_q <= rd ? rd_mux : 16'h0000;
        end
    end

    assign rdata     = rdata_q;
    assign dout_pins = out_q;
    assign irq       = irq_q;

    // ************************************
    // Assertions
    // ************************************
    property p_irq_tracks_src;
        @(posedge clk) disable iff (rst) irq == (|src_q);
    endproperty
    a_irq_tracks_src: assert property (p_irq_tracks_src) else $error("irq off source");

    property p_src_sets;
        @(posedge clk) disable iff (rst) src_pulse[0] |=> src_q[0];
    endproperty
    a_src_sets: assert property (p_src_sets) else $error("event 1 bit not set");

    property p_multi_src;
        @(posedge clk) disable iff (rst) (src_pulse == 8'hFF) |=> (src_q == 8'hFF);
    endproperty
    a_multi_src: assert property (p_multi_src) else $error("sources not kept together");

    property p_src_read;
        @(posedge clk) disable iff (rst) rd_src |=> rdata == {8'h00, $past(src_q)};
    endproperty
    a_src_read: assert property (p_src_read) else $error("source read wrong");

    property p_clr_on_read;
        @(posedge clk) disable iff (rst) (rd_src && src_pulse == 8'h00) |=> src_q == 8'h00;
    endproperty
    a_clr_on_read: assert property (p_clr_on_read) else $error("source not cleared");

    property p_word_read;
        @(posedge clk) disable iff (rst)
            (rd && addr == `IDIO_OFF_INPUTS) |=> rdata == $past(din_sync);
    endproperty
    a_word_read: assert property (p_word_read) else $error("input word wrong");

    property p_port2_read;
        @(posedge clk) disable iff (rst)
            (rd && addr == `IDIO_OFF_PORT2) |=> rdata == {8'h00, $past(din_sync[15:8])};
    endproperty
    a_port2_read: assert property (p_port2_read) else $error("port 2 wrong");

    property p_chan_read;
        @(posedge clk) disable iff (rst)
            (rd && addr == `IDIO_OFF_CHAN_LVL) |=> rdata == {15'h0000, $past(single_lvl)};
    endproperty
    a_chan_read: assert property (p_chan_read) else $error("channel level wrong");

    property p_out_write;
        @(posedge clk) disable iff (rst) wr_out |=> dout_pins == $past(wdata);
    endproperty
    a_out_write: assert property (p_out_write) else $error("outputs not written");

    property p_bit0_in1;
        @(posedge clk) disable iff (rst)
            (rd && addr == `IDIO_OFF_PORT1) |=> rdata[0] == $past(din_sync[0]);
    endproperty
    a_bit0_in1: assert property (p_bit0_in1) else $error("input 1 not at bit 0");

    // ************************************
    // Source byte sequences
    // ************************************
    sequence s_src_caught;
        src_pulse != 8'h00;
    endsequence

    sequence s_src_read_clean;
        rd_src && (src_pulse == 8'h00);
    endsequence

    sequence s_src_read_hit;
        rd_src && (src_pulse != 8'h00);
    endsequence

    sequence s_src_quiet;
        !rd_src && (src_pulse == 8'h00);
    endsequence

    sequence s_src_cleared;
        (src_q == 8'h00) && !irq;
    endsequence

    // ************************************
    // Source byte and request checks
    // ************************************
    property p_irq_rise;
        @(posedge clk) disable iff (rst)
            s_src_caught |=> irq;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq not raised by source");

    property p_read_clears;
        @(posedge clk) disable iff (rst)
            s_src_read_clean |=> s_src_cleared;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear");

    property p_set_wins;
        @(posedge clk) disable iff (rst)
            s_src_read_hit |=> (src_q == $past(src_pulse)) && irq;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost to read clear");

    property p_src_keep;
        @(posedge clk) disable iff (rst)
            s_src_caught |=> ((src_q & $past(src_pulse)) == $past(src_pulse));
    endproperty
    a_src_keep: assert property (p_src_keep) else $error("source bit dropped");

    property p_src_hold;
        @(posedge clk) disable iff (rst)
            s_src_quiet |=> $stable(src_q);
    endproperty
    a_src_hold: assert property (p_src_hold) else $error("source byte moved");

    property p_irq_source;
        @(posedge clk) disable iff (rst)
            (rd_src && irq) |=> rdata[7:0] != 8'h00;
    endproperty
    a_irq_source: assert property (p_irq_source) else $error("irq without cause");

    // ************************************
    // Register port checks
    // ************************************
    property p_port1_read;
        @(posedge clk) disable iff (rst)
            rd_prt1 |=> rdata == {8'h00, $past(din_sync[7:0])};
    endproperty
    a_port1_read: assert property (p_port1_read) else $error("port 1 wrong");

    property p_lvl_upper;
        @(posedge clk) disable iff (rst)
            rd_lvl |=> rdata[15:1] == 15'h0000;
    endproperty
    a_lvl_upper: assert property (p_lvl_upper) else $error("level upper bits set");

    property p_sel_write;
        @(posedge clk) disable iff (rst)
            wr_sel |=> chan_sel_q == $past(wdata[3:0]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("select not written");

    property p_sel_read;
        @(posedge clk) disable iff (rst)
            rd_sel |=> rdata == {12'h000, $past(chan_sel_q)};
    endproperty
    a_sel_read: assert property (p_sel_read) else $error("select readback wrong");

    property p_out_hold;
        @(posedge clk) disable iff (rst)
            !wr_out |=> $stable(dout_pins);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("outputs moved");

    property p_out_read;
        @(posedge clk) disable iff (rst)
            rd_out |=> rdata == $past(dout_pins);
    endproperty
    a_out_read: assert property (p_out_read) else $error("outputs readback wrong");

    property p_rdata_idle;
        @(posedge clk) disable iff (rst)
            !rd |=> rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

    property p_word_order;
        @(posedge clk) disable iff (rst)
            rd_word |=> rdata[15] == $past(din_sync[15]);
    endproperty
    a_word_order: assert property (p_word_order) else $error("input 16 not at bit 15");

    property p_port2_in9;
        @(posedge clk) disable iff (rst)
            rd_prt2 |=> rdata[0] == $past(din_sync[8]);
    endproperty
    a_port2_in9: assert property (p_port2_in9) else $error("input 9 not at bit 0");
endmodule
`default_nettype wire

// File: verification/idio_host_model.sv
// Purpose: Host master on the register port
// Assumes: Read data stand one cycle after rd
// Notes:   Strobes move just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module idio_host_model (
    input  wire logic        clk,
    output var  logic [3:0]  addr,
    output var  logic [15:0] wdata,
    output var  logic        wr,
    output var  logic        rd,
    input  wire logic [15:0] rdata
);
    initial {addr, wdata, wr, rd} = 22'h000000;

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask
endmodule
`default_nettype wire

// File: verification/idio_top_tb.sv
// Purpose: Self-checking bench for the digital I/O block
// Assumes: Host model drives the register port
// Notes:   Prints mismatches and verdict only
`timescale 1ns/100ps
`default_nettype none
`include "idio_consts.svh"
module idio_top_tb;
    logic        clk;
    logic        rst;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic [15:0] din_pins;
    logic [15:0] dout_pins;
    logic [7:0]  src_pulse;
    logic        irq;
    logic [15:0] v;
    int          fails = 0;
    int          compares = 0;

    idio_top u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .din_pins(din_pins), .dout_pins(dout_pins),
        .src_pulse(src_pulse), .irq(irq));
    idio_host_model u_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata));

    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic finish_test;
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic t_outputs;
        u_host.wr_reg(`IDIO_OFF_OUTPUTS, 16'h5555);
        #1 check("dout_pins", 16'h5555, dout_pins);
        u_host.wr_reg(`IDIO_OFF_OUTPUTS, 16'hAAAA);
        #1 check("dout_pins", 16'hAAAA, dout_pins);
        u_host.rd_reg(`IDIO_OFF_OUTPUTS, v);
        check("outputs readback", 16'hAAAA, v);
        u_host.rd_reg(4'hF, v);
        check("unmapped", 16'h0000, v);
    endtask

    task automatic t_inputs(input logic [15:0] p);
        @(posedge clk) din_pins <= p;
        repeat (6) @(posedge clk);
        u_host.rd_reg(`IDIO_OFF_INPUTS, v);
        check("all_inputs_word", p, v);
        u_host.rd_reg(`IDIO_OFF_PORT1, v);
        check("input_port_byte 1", {8'h00, p[7:0]}, v);
        u_host.rd_reg(`IDIO_OFF_PORT2, v);
        check("input_port_byte 2", {8'h00, p[15:8]}, v);
        for (int c = 0; c < 16; c++) begin
            u_host.wr_reg(`IDIO_OFF_CHAN_SEL, 16'(c));
            u_host.rd_reg(`IDIO_OFF_CHAN_LVL, v);
            check("single_input_level", {15'h0000, p[c]}, v);
        end
    endtask

    task automatic t_source(input logic [7:0] m);
        @(posedge clk) src_pulse <= m;
        @(posedge clk) src_pulse <= 8'h00;
        #1 check("irq", 16'h0001, {15'h0000, irq});
        u_host.rd_reg(`IDIO_OFF_IRQ_SRC, v);
        check("interrupt_source_byte", {8'h00, m}, v);
        check("irq after read", 16'h0000, {15'h0000, irq});
        u_host.rd_reg(`IDIO_OFF_IRQ_SRC, v);
        check("source after read", 16'h0000, v);
    endtask

    task automatic t_src_clash(input logic [7:0] m);
        fork
            u_host.rd_reg(`IDIO_OFF_IRQ_SRC, v);
            begin
                @(posedge clk) src_pulse <= m;
                @(posedge clk) src_pulse <= 8'h00;
            end
        join
        check("source read in clash", 16'h0000, v);
        check("irq after clash", 16'h0001, {15'h0000, irq});
        u_host.rd_reg(`IDIO_OFF_IRQ_SRC, v);
        check("source kept in clash", {8'h00, m}, v);
    endtask

    task automatic t_reset;
        u_host.wr_reg(`IDIO_OFF_OUTPUTS, 16'hFFFF);
        u_host.wr_reg(`IDIO_OFF_CHAN_SEL, 16'h0009);
        @(posedge clk) src_pulse <= 8'h81;
        @(posedge clk) begin
            src_pulse <= 8'h00;
            rst <= 1'b1;
        end
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1 check("dout_pins reset", 16'h0000, dout_pins);
        check("irq reset", 16'h0000, {15'h0000, irq});
        u_host.rd_reg(`IDIO_OFF_IRQ_SRC, v);
        check("source reset", 16'h0000, v);
        u_host.rd_reg(`IDIO_OFF_CHAN_SEL, v);
        check("select reset", 16'h0000, v);
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        din_pins = 16'h0000;
        src_pulse = 8'h00;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1 check("dout_pins reset", 16'h0000, dout_pins);
        t_outputs();
        t_inputs(16'h5555);
        t_inputs(16'hA53C);
        for (int i = 0; i < 8; i++) t_source(8'(1 << i));
        t_source(8'hC5);
        t_source(8'hFF);
        t_src_clash(8'h24);
        t_reset();
        finish_test();
    end

    initial begin
        #1000000;
        fails++;
        finish_test();
    end
endmodule
`default_nettype wire
